// ### design/lvr_map.svh
// Register indices, field positions, reset values and timing counts
`ifndef LVR_MAP_SVH
`define LVR_MAP_SVH

`define LVR_IDX_FIFO_LEVEL      8'h4A
`define LVR_IDX_LOW_OFS_LO      8'h4B
`define LVR_IDX_LOW_OFS_HI      8'h4C
`define LVR_IDX_OVF_ONE         8'h50
`define LVR_IDX_OVF_TWO         8'h51
`define LVR_IDX_HTOTAL_LO       8'h52
`define LVR_IDX_HDE_LO          8'h53
`define LVR_IDX_HSS_LO          8'h54
`define LVR_IDX_VTOTAL_LO       8'h55
`define LVR_IDX_VDE_LO          8'h56
`define LVR_IDX_VSS_LO          8'h57

`define LVR_FIFO_LEVEL_RST      8'h44
`define LVR_FIFO_LEVEL_MASK     8'hF3
`define LVR_LOW_OFS_HI_MASK     8'hC0
`define LVR_OVF_ONE_MASK        8'h0F

`define LVR_LVL_LOWER_HI        7
`define LVR_LVL_LOWER_LO        6
`define LVR_LVL_UPPER_HI        5
`define LVR_LVL_UPPER_LO        4
`define LVR_LVL_WRITE_HI        1
`define LVR_LVL_WRITE_LO        0

`define LVR_LEVEL_4             5'h04
`define LVR_LEVEL_8             5'h08
`define LVR_LEVEL_12            5'h0C

`define LVR_PANEL_DSTN          2'h1
`define LVR_OFS_SHIFT           3
`define LVR_CHAR_LAST           3'h7
`define LVR_HSYNC_NARROW        9'h001
`define LVR_HSYNC_WIDE          9'h002

`endif

// ### design/lvr_pkg.sv
// Types shared by the virtual refresh timing generator
package lvr_pkg;

    typedef struct packed {
        logic [8:0]  htotal;
        logic [8:0]  hde;
        logic [8:0]  hss;
        logic [10:0] vtotal;
        logic [10:0] vde;
        logic [10:0] vss;
    } lvr_timing_t;

    typedef struct packed {
        logic de;
        logic hsync;
        logic vsync;
    } lvr_panel_t;

    typedef struct packed {
        logic lower_rd;
        logic upper_rd;
        logic frame_wr;
    } lvr_req_t;

endpackage

// ### design/lvr_timing.sv
// Virtual refresh flat-panel timing generator with FIFO request control
//
// Overview of operation
// - Lower read FIFO requests at 4, 8 or 12 empty entries per bits 7:6.
// - Upper read FIFO requests at 4, 8 or 12 empty entries per bits 5:4.
// - Write FIFO requests at 4, 8 or 12 filled entries per bits 1:0.
// - Request level register resets to 44h.
// - Next lower line address is current start plus 10-bit offset.
// - Offset low byte lands on memory address bits 10:3.
// - Offset bits 9:8 come from offset high register bits 7:6; bits 5:0 reserved.
// - Overflow one holds vertical total 10:8 and hsync start bit 8.
// - Overflow two holds vsync start, vertical end, hde and htotal high bits.
// - Horizontal total counts eight-pixel characters per line, less one.
// - Horizontal sync or line pulse starts at programmed start count.
// - Hsync pulse is 8 or 16 pixels per width-select bit.
// - Totals act only while virtual refresh is enabled.
// - Virtual refresh enable turns timing on; panel type 01b means DSTN.
// - Vertical sync or frame pulse lasts exactly one line.
`include "lvr_map.svh"

module lvr_timing (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_b_i,
    // Indexed register port
    input  wire logic [7:0]  reg_index_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    output logic      [7:0]  reg_rdata_o,
    // Mode controls held elsewhere
    input  wire logic        vr_enable_i,
    input  wire logic [1:0]  panel_type_i,
    input  wire logic        hsync_wide_i,
    // FIFO levels
    input  wire logic [4:0]  lower_fifo_empty_i,
    input  wire logic [4:0]  upper_fifo_empty_i,
    input  wire logic [4:0]  write_fifo_filled_i,
    // Lower panel line start
    input  wire logic [18:0] lower_start_addr_i,
    output logic      [18:0] lower_line_addr_o,
    // Memory requests
    output lvr_pkg::lvr_req_t req_o,
    // Panel timing
    output lvr_pkg::lvr_panel_t panel_o,
    output logic             dstn_mode_o
);

    logic [7:0] fifo_request_level;
    logic [7:0] lower_read_offset_low;
    logic [7:0] lower_read_offset_high;
    logic [7:0] timing_overflow_one;
    logic [7:0] timing_overflow_two;
    logic [7:0] horiz_total_low;
    logic [7:0] horiz_display_end_low;
    logic [7:0] horiz_sync_start_low;
    logic [7:0] vert_total_low;
    logic [7:0] vert_display_end_low;
    logic [7:0] vert_sync_start_low;

    lvr_pkg::lvr_timing_t tm;
    logic [9:0]  lower_offset;
    logic [18:0] lower_step;
    logic [7:0]  next_rdata;

    logic [2:0]  pix_cnt;
    logic        char_en;
    logic [8:0]  hcnt;
    logic [10:0] vcnt;
    logic        h_wrap;
    logic        v_wrap;
    logic [8:0]  hs_width;
    logic [8:0]  hs_end;
    logic [8:0]  next_hcnt;
    logic [10:0] next_vcnt;
    logic [18:0] next_line_addr;
    lvr_pkg::lvr_panel_t next_panel;
    lvr_pkg::lvr_req_t   next_req;

    // Threshold count for a two-bit request level code
    function automatic logic [4:0] level_count(input logic [1:0] code);
        logic [4:0] cnt;
        cnt = `LVR_LEVEL_4;
        case (code)
            2'h0: cnt = `LVR_LEVEL_4;
            2'h1: cnt = `LVR_LEVEL_8;
            default: cnt = `LVR_LEVEL_12;
        endcase
        return cnt;
    endfunction

    // Write strobe aimed at one register index
    function automatic logic reg_hit(input logic [7:0] idx, input logic [7:0] sel,
                                     input logic wr);
        return wr && idx == sel;
    endfunction

    // Request level register
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            fifo_request_level <= `LVR_FIFO_LEVEL_RST;
        end else if (reg_hit(reg_index_i, `LVR_IDX_FIFO_LEVEL, reg_wr_i)) begin
            fifo_request_level <= reg_wdata_i & `LVR_FIFO_LEVEL_MASK;
        end
    end

    // Lower panel line offset registers
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            lower_read_offset_low <= 8'h00;
        end else if (reg_hit(reg_index_i, `LVR_IDX_LOW_OFS_LO, reg_wr_i)) begin
            lower_read_offset_low <= reg_wdata_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            lower_read_offset_high <= 8'h00;
        end else if (reg_hit(reg_index_i, `LVR_IDX_LOW_OFS_HI, reg_wr_i)) begin
            lower_read_offset_high <= reg_wdata_i & `LVR_LOW_OFS_HI_MASK;
        end
    end

    // Timing overflow registers
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            timing_overflow_one <= 8'h00;
        end else if (reg_hit(reg_index_i, `LVR_IDX_OVF_ONE, reg_wr_i)) begin
            timing_overflow_one <= reg_wdata_i & `LVR_OVF_ONE_MASK;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            timing_overflow_two <= 8'h00;
        end else if (reg_hit(reg_index_i, `LVR_IDX_OVF_TWO, reg_wr_i)) begin
            timing_overflow_two <= reg_wdata_i;
        end
    end

    // Horizontal low bytes
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            horiz_total_low <= 8'h00;
        end else if (reg_hit(reg_index_i, `LVR_IDX_HTOTAL_LO, reg_wr_i)) begin
            horiz_total_low <= reg_wdata_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            horiz_display_end_low <= 8'h00;
        end else if (reg_hit(reg_index_i, `LVR_IDX_HDE_LO, reg_wr_i)) begin
            horiz_display_end_low <= reg_wdata_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            horiz_sync_start_low <= 8'h00;
        end else if (reg_hit(reg_index_i, `LVR_IDX_HSS_LO, reg_wr_i)) begin
            horiz_sync_start_low <= reg_wdata_i;
        end
    end

    // Vertical low bytes
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            vert_total_low <= 8'h00;
        end else if (reg_hit(reg_index_i, `LVR_IDX_VTOTAL_LO, reg_wr_i)) begin
            vert_total_low <= reg_wdata_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            vert_display_end_low <= 8'h00;
        end else if (reg_hit(reg_index_i, `LVR_IDX_VDE_LO, reg_wr_i)) begin
            vert_display_end_low <= reg_wdata_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            vert_sync_start_low <= 8'h00;
        end else if (reg_hit(reg_index_i, `LVR_IDX_VSS_LO, reg_wr_i)) begin
            vert_sync_start_low <= reg_wdata_i;
        end
    end

    // Read data, one cycle after the index
    always_comb begin
        next_rdata = 8'h00;
        case (reg_index_i)
            `LVR_IDX_FIFO_LEVEL: next_rdata = fifo_request_level;
            `LVR_IDX_LOW_OFS_LO: next_rdata = lower_read_offset_low;
            `LVR_IDX_LOW_OFS_HI: next_rdata = lower_read_offset_high;
            `LVR_IDX_OVF_ONE:    next_rdata = timing_overflow_one;
            `LVR_IDX_OVF_TWO:    next_rdata = timing_overflow_two;
            `LVR_IDX_HTOTAL_LO:  next_rdata = horiz_total_low;
            `LVR_IDX_HDE_LO:     next_rdata = horiz_display_end_low;
            `LVR_IDX_HSS_LO:     next_rdata = horiz_sync_start_low;
            `LVR_IDX_VTOTAL_LO:  next_rdata = vert_total_low;
            `LVR_IDX_VDE_LO:     next_rdata = vert_display_end_low;
            `LVR_IDX_VSS_LO:     next_rdata = vert_sync_start_low;
            default:             next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= next_rdata;
        end
    end

    // Assemble full-width timing values
    always_comb begin
        tm.vtotal = {timing_overflow_one[3:1], vert_total_low};
        tm.hss    = {timing_overflow_one[0], horiz_sync_start_low};
        tm.vss    = {timing_overflow_two[7:5], vert_sync_start_low};
        tm.vde    = {timing_overflow_two[4:2], vert_display_end_low};
        tm.hde    = {timing_overflow_two[1], horiz_display_end_low};
        tm.htotal = {timing_overflow_two[0], horiz_total_low};
    end

    // Offset in eight-byte units
    assign lower_offset = {lower_read_offset_high[7:6], lower_read_offset_low};
    assign lower_step   = {9'h000, lower_offset} << `LVR_OFS_SHIFT;

    // Character clock enable: one pulse per eight pixels
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i || !vr_enable_i) begin
            pix_cnt <= 3'h0;
        end else begin
            pix_cnt <= pix_cnt + 3'h1;
        end
    end

    assign char_en = vr_enable_i && pix_cnt == `LVR_CHAR_LAST;

    assign h_wrap = char_en && hcnt >= tm.htotal;
    assign v_wrap = h_wrap && vcnt >= tm.vtotal;

    // Next counts: characters wrap at the total and step the line
    always_comb begin
        next_hcnt = hcnt;
        next_vcnt = vcnt;
        if (h_wrap) begin
            next_hcnt = 9'h000;
        end else if (char_en) begin
            next_hcnt = hcnt + 9'h001;
        end
        if (v_wrap) begin
            next_vcnt = 11'h000;
        end else if (h_wrap) begin
            next_vcnt = vcnt + 11'h001;
        end
    end

    // Character and line counters, idle outside virtual refresh
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i || !vr_enable_i) begin
            hcnt <= 9'h000;
        end else begin
            hcnt <= next_hcnt;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i || !vr_enable_i) begin
            vcnt <= 11'h000;
        end else begin
            vcnt <= next_vcnt;
        end
    end

    // Sync window in characters
    assign hs_width = hsync_wide_i ? `LVR_HSYNC_WIDE : `LVR_HSYNC_NARROW;
    assign hs_end   = tm.hss + hs_width;

    // Next panel levels; sync start above display end keeps pulses in blanking
    always_comb begin
        next_panel       = '0;
        next_panel.de    = hcnt <= tm.hde && vcnt <= tm.vde;
        next_panel.hsync = hcnt >= tm.hss && hcnt < hs_end;
        next_panel.vsync = vcnt == tm.vss;
    end

    // Panel timing outputs
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i || !vr_enable_i) begin
            panel_o <= '0;
        end else begin
            panel_o <= next_panel;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            dstn_mode_o <= 1'b0;
        end else begin
            dstn_mode_o <= panel_type_i == `LVR_PANEL_DSTN;
        end
    end

    // Reload at frame wrap so a line offset never drifts across frames
    always_comb begin
        next_line_addr = lower_line_addr_o;
        if (v_wrap) begin
            next_line_addr = lower_start_addr_i;
        end else if (h_wrap) begin
            next_line_addr = lower_line_addr_o + lower_step;
        end
    end

    // Lower panel line start address
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i || !vr_enable_i) begin
            lower_line_addr_o <= lower_start_addr_i;
        end else begin
            lower_line_addr_o <= next_line_addr;
        end
    end

    // Threshold compares, re-evaluated every cycle
    always_comb begin
        next_req          = '0;
        next_req.lower_rd = lower_fifo_empty_i >= level_count(fifo_request_level[7:6]);
        next_req.upper_rd = upper_fifo_empty_i >= level_count(fifo_request_level[5:4]);
        next_req.frame_wr = write_fifo_filled_i >= level_count(fifo_request_level[1:0]);
    end

    // FIFO memory requests, level-following
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            req_o <= '0;
        end else begin
            req_o <= next_req;
        end
    end

endmodule

// ### sim/lvr_checker.sv
// Assertion checker for the virtual refresh timing generator
module lvr_checker (
    // Clock and reset
    input wire logic           mclk_i,
    input wire logic           rst_b_i,
    // Register port
    input wire logic [7:0]     reg_index_i,
    input wire logic [7:0]     reg_wdata_i,
    input wire logic           reg_wr_i,
    input wire logic [7:0]     reg_rdata_o,
    // Controls and levels
    input wire logic           vr_enable_i,
    input wire logic [1:0]     panel_type_i,
    input wire logic           hsync_wide_i,
    input wire logic [4:0]     lower_fifo_empty_i,
    input wire logic [4:0]     upper_fifo_empty_i,
    input wire logic [4:0]     write_fifo_filled_i,
    // Outputs
    input lvr_pkg::lvr_req_t   req_o,
    input lvr_pkg::lvr_panel_t panel_o,
    input wire logic           dstn_mode_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);
    logic [7:0]  lvl;
    logic [8:0]  ht;
    logic [12:0] hs_n;
    logic [12:0] vs_n;
    function automatic logic [4:0] thr(input logic [1:0] f);
        return f[1] ? 5'h0C : (f[0] ? 5'h08 : 5'h04);
    endfunction
    // Shadows of the level and line length registers
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            lvl <= 8'h44;
            ht  <= 9'h000;
        end else if (reg_wr_i) begin
            if (reg_index_i == 8'h4A) lvl <= reg_wdata_i & 8'hF3;
            if (reg_index_i == 8'h52) ht[7:0] <= reg_wdata_i;
            if (reg_index_i == 8'h51) ht[8] <= reg_wdata_i[0];
        end
    end
    // Lengths of running sync pulses
    always_ff @(posedge mclk_i) begin
        hs_n <= (rst_b_i && panel_o.hsync) ? hs_n + 13'h0001 : 13'h0000;
        vs_n <= (rst_b_i && panel_o.vsync) ? vs_n + 13'h0001 : 13'h0000;
    end
    property p_low;
        $past(rst_b_i) |-> req_o.lower_rd == ($past(lower_fifo_empty_i) >= thr($past(lvl[7:6])));
    endproperty
    a_low: assert property (p_low) else $error("lower request wrong");
    property p_up;
        $past(rst_b_i) |-> req_o.upper_rd == ($past(upper_fifo_empty_i) >= thr($past(lvl[5:4])));
    endproperty
    a_up: assert property (p_up) else $error("upper request wrong");
    property p_wr;
        $past(rst_b_i) |-> req_o.frame_wr == ($past(write_fifo_filled_i) >= thr($past(lvl[1:0])));
    endproperty
    a_wr: assert property (p_wr) else $error("write request wrong");
    property p_rd;
        $past(rst_b_i) && $past(reg_index_i) == 8'h4A |-> reg_rdata_o == $past(lvl);
    endproperty
    a_rd: assert property (p_rd) else $error("level readback wrong");
    property p_dstn;
        $past(rst_b_i) |-> dstn_mode_o == ($past(panel_type_i) == 2'h1);
    endproperty
    a_dstn: assert property (p_dstn) else $error("panel type flag wrong");
    property p_off;
        $past(rst_b_i) && !$past(vr_enable_i) |-> panel_o == 3'h0;
    endproperty
    a_off: assert property (p_off) else $error("timing active while off");
    property p_hs;
        $fell(panel_o.hsync) && vr_enable_i && $past(vr_enable_i)
            |-> hs_n == (hsync_wide_i ? 13'h0010 : 13'h0008);
    endproperty
    a_hs: assert property (p_hs) else $error("hsync width wrong");
    property p_vs;
        $fell(panel_o.vsync) && vr_enable_i && $past(vr_enable_i)
            |-> vs_n == (13'(ht) + 13'h0001) * 13'h0008;
    endproperty
    a_vs: assert property (p_vs) else $error("vsync not one line");
    c_wide: cover property ($rose(panel_o.hsync) && hsync_wide_i);
    c_vs: cover property ($rose(panel_o.vsync));
    c_wr: cover property ($rose(req_o.frame_wr));
endmodule

bind lvr_timing lvr_checker lvr_checker_inst (.mclk_i, .rst_b_i, .reg_index_i, .reg_wdata_i,
    .reg_wr_i, .reg_rdata_o, .vr_enable_i, .panel_type_i, .hsync_wide_i, .lower_fifo_empty_i,
    .upper_fifo_empty_i, .write_fifo_filled_i, .req_o, .panel_o, .dstn_mode_o);

// ### sim/lvr_panel_model.sv
// Panel side model that measures the timing it receives
module lvr_panel_model (
    // Clock and panel timing
    input wire logic           mclk_i,
    input lvr_pkg::lvr_panel_t panel_i,
    // Measured figures in clocks and lines
    output logic [12:0]        line_o,
    output logic [12:0]        de_o,
    output logic [12:0]        gap_o,
    output logic [12:0]        hw_o,
    output logic [10:0]        lines_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [12:0] t, d, g, h;
    logic [10:0] n;
    logic        hs_q, de_q, vs_q;
    always_ff @(posedge mclk_i) begin
        hs_q <= panel_i.hsync;
        de_q <= panel_i.de;
        vs_q <= panel_i.vsync;
        // Line period in eight-pixel characters times eight
        t <= (panel_i.hsync && !hs_q) ? 13'h0001 : t + 13'h0001;
        d <= panel_i.de ? d + 13'h0001 : 13'h0000;
        g <= (!panel_i.de && de_q) ? 13'h0001 : g + 13'h0001;
        h <= panel_i.hsync ? h + 13'h0001 : 13'h0000;
        if (panel_i.hsync && !hs_q) line_o <= t;
        if (panel_i.hsync && !hs_q) gap_o <= g;
        if (!panel_i.de && de_q) de_o <= d;
        if (!panel_i.hsync && hs_q) hw_o <= h;
        n <= (panel_i.vsync && !vs_q) ? 11'h000 : n + {10'h000, panel_i.hsync && !hs_q};
        if (panel_i.vsync && !vs_q) lines_o <= n;
    end
endmodule

// ### sim/tb_lvr_timing.sv
// Self-checking bench for the virtual refresh timing generator
module tb_lvr_timing;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int          W   = 32'h808;
    localparam logic [8:0]  HT  = 9'((W + 32'h20) / 32'h8 - 32'h1);
    localparam logic [8:0]  HDE = 9'(W / 32'h8 - 32'h1);
    localparam logic [8:0]  HSS = HDE + 9'h002;
    localparam logic [10:0] VT  = 11'h003; // Two lines, two blank
    localparam logic [10:0] VDE = 11'h001;
    localparam logic [10:0] VSS = 11'h002;
    logic                mclk_i, rst_b_i, reg_wr_i, vr_enable_i, hsync_wide_i, dstn_mode_o;
    logic [1:0]          panel_type_i;
    logic [4:0]          lower_fifo_empty_i, upper_fifo_empty_i, write_fifo_filled_i;
    logic [7:0]          reg_index_i, reg_wdata_i, reg_rdata_o, d;
    logic [18:0]         lower_start_addr_i, lower_line_addr_o;
    logic [12:0]         line_m, de_m, gap_m, hw_m;
    logic [10:0]         lines_m;
    logic [31:0]         s, v, ofs;
    lvr_pkg::lvr_req_t   req_o;
    lvr_pkg::lvr_panel_t panel_o;
    int                  n_fail, checks, i, j, k;
    logic [7:0]          ix [11] = '{8'h4A, 8'h4B, 8'h4C, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54,
                                    8'h55, 8'h56, 8'h57};
    logic [7:0]          mk [11] = '{8'hF3, 8'hFF, 8'hC0, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                                    8'hFF, 8'hFF, 8'hFF};
    lvr_timing lvr_timing_inst (.mclk_i, .rst_b_i, .reg_index_i, .reg_wdata_i, .reg_wr_i,
        .reg_rdata_o, .vr_enable_i, .panel_type_i, .hsync_wide_i, .lower_fifo_empty_i,
        .upper_fifo_empty_i, .write_fifo_filled_i, .lower_start_addr_i, .lower_line_addr_o,
        .req_o, .panel_o, .dstn_mode_o);
    lvr_panel_model lvr_panel_model_inst (.mclk_i, .panel_i(panel_o), .line_o(line_m),
        .de_o(de_m), .gap_o(gap_m), .hw_o(hw_m), .lines_o(lines_m));
    function automatic logic [31:0] rnd();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    function automatic logic [4:0] thr(input logic [1:0] f);
        return f[1] ? 5'h0C : (f[0] ? 5'h08 : 5'h04);
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        @(posedge mclk_i);
        #1;
        {reg_index_i, reg_wdata_i, reg_wr_i} = {a, x, 1'b1};
        @(posedge mclk_i);
        #1;
        reg_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] x);
        @(posedge mclk_i);
        #1;
        reg_index_i = a;
        @(posedge mclk_i);
        #1;
        x = reg_rdata_o;
    endtask
    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    // Tests take about 40000 clocks; twice that is a hang
    initial begin
        #400000;
        n_fail++;
        report_and_stop();
    end
    initial begin
        s = 32'h0EE0;
        {rst_b_i, reg_wr_i, vr_enable_i, hsync_wide_i, panel_type_i} = '0;
        {reg_index_i, reg_wdata_i, lower_start_addr_i} = '0;
        {lower_fifo_empty_i, upper_fifo_empty_i, write_fifo_filled_i} = '0;
        repeat (3) @(posedge mclk_i);
        #1;
        rst_b_i = 1'b1;
        for (i = 0; i < 11; i++) begin
            rd(ix[i], d);
            chk("reset value", (i == 0) ? 8'h44 : 8'h00, d);
        end
        for (i = 0; i < 22; i++) begin
            v = rnd();
            wr(ix[i % 11], v[7:0]);
            rd(ix[i % 11], d);
            chk("readback", v[7:0] & mk[i % 11], d);
        end
        wr(8'h60, 8'hA5);
        rd(8'h60, d);
        chk("unmapped", 8'h00, d);
        $display("test registers done");
        for (i = 0; i < 4; i++) begin
            wr(8'h4A, {i[1:0], i[1:0], 2'h0, i[1:0]});
            for (j = 0; j < 8; j++) begin
                v = rnd();
                @(posedge mclk_i);
                #1;
                lower_fifo_empty_i = (j < 2) ? thr(i[1:0]) - {4'h0, ~j[0]} : v[4:0];
                upper_fifo_empty_i = (j < 2) ? thr(i[1:0]) - {4'h0, j[0]} : v[9:5];
                write_fifo_filled_i = (j < 2) ? thr(i[1:0]) - {4'h0, ~j[0]} : v[14:10];
                @(posedge mclk_i);
                #1;
                chk("lower req", thr(i[1:0]) <= lower_fifo_empty_i, req_o.lower_rd);
                chk("upper req", thr(i[1:0]) <= upper_fifo_empty_i, req_o.upper_rd);
                chk("write req", thr(i[1:0]) <= write_fifo_filled_i, req_o.frame_wr);
            end
        end
        $display("test requests done");
        ofs = rnd();
        wr(8'h4B, ofs[7:0]);
        wr(8'h4C, {ofs[9:8], 6'h00});
        wr(8'h52, HT[7:0]);
        wr(8'h53, HDE[7:0]);
        wr(8'h54, HSS[7:0]);
        wr(8'h55, VT[7:0]);
        wr(8'h56, VDE[7:0]);
        wr(8'h57, VSS[7:0]);
        wr(8'h50, {4'h0, VT[10:8], HSS[8]});
        wr(8'h51, {VSS[10:8], VDE[10:8], HDE[8], HT[8]});
        for (j = 0; j < 2; j++) begin
            v = rnd();
            lower_start_addr_i = v[18:0];
            hsync_wide_i = j[0];
            panel_type_i = {1'b0, j[0]};
            repeat (2) @(posedge mclk_i);
            #1;
            vr_enable_i = 1'b1;
            k = 0;
            while (k < 3000 && lower_line_addr_o === v[18:0]) begin
                @(posedge mclk_i);
                #1;
                k++;
            end
            chk("line address", 19'(v[18:0] + {ofs[9:0], 3'h0}), lower_line_addr_o);
            repeat (17000) @(posedge mclk_i);
            #1;
            chk("line period", (HT + 32'h1) * 32'h8, line_m);
            chk("de length", (HDE + 32'h1) * 32'h8, de_m);
            chk("sync gap", (HSS - HDE - 32'h1) * 32'h8, gap_m);
            chk("sync width", j ? 32'h10 : 32'h8, hw_m);
            chk("frame lines", VT + 32'h1, lines_m);
            chk("panel type", j, dstn_mode_o);
            chk("line reload", 19'(v[18:0] + {ofs[9:0], 3'h0}), lower_line_addr_o);
            vr_enable_i = 1'b0;
            repeat (2) @(posedge mclk_i);
            #1;
            chk("disabled", 32'h0, panel_o);
            $display("test timing %0d done", j);
        end
        report_and_stop();
    end
endmodule
